// ### logic/event_router_regs.svh
// Register map, field positions, reset values and timing of the event input router
`ifndef EVENT_ROUTER_REGS_SVH
`define EVENT_ROUTER_REGS_SVH

`define ADDR_W 8
`define DATA_W 32
`define FUNC_W 5

`define REG_ASSIGN_BASE 8'h00
`define REG_ASSIGN_LAST 8'h14
`define REG_CFG 8'h18
`define REG_STATUS 8'h1C
`define REG_INPUTS 8'h20

`define WORD_LSB 2
`define WORD_MSB 4

`define CFG_REVERSE_BIT 0
`define CFG_PROG_EN_BIT 1
`define CFG_RSP_AVAIL_BIT 2
`define CFG_HEAT_COOL_BIT 3
`define CFG_W 4
`define CFG_RESET 4'h7

`define ST_STOP_BIT 0
`define ST_MANUAL_BIT 1
`define ST_PROG_RUN_BIT 2
`define ST_PROG_END_BIT 3
`define ST_REV_EFF_BIT 4
`define ST_RSP_BIT 5
`define ST_AT_FULL_BIT 6
`define ST_AT_RED_BIT 7
`define ST_LOCK_BIT 8
`define ST_COMM_BIT 9
`define ST_FILTER_BIT 10
`define ST_WATER_BIT 11
`define ST_TMODE_BIT 12
`define ST_TUNE1_BIT 13
`define ST_TUNE2_BIT 14
`define ST_ALARM_EN_BIT 15
`define ST_W 16

`define QUAL_TIME_MS 50
`define CLK_FREQ_KHZ 200000
`define NUM_EVENT_INPUTS 6

`endif

// ### logic/event_router_pkg.sv
// Types shared by the event input router
package event_router_pkg;

	typedef enum logic [4:0] {
		FN_NONE = 5'h00,
		FN_STOP = 5'h01,
		FN_MANUAL = 5'h02,
		FN_PROG = 5'h03,
		FN_DIR_INV = 5'h04,
		FN_SP_SRC = 5'h05,
		FN_AT_FULL = 5'h06,
		FN_AT_RED = 5'h07,
		FN_SET_LOCK = 5'h08,
		FN_COMM_WR = 5'h09,
		FN_LATCH_CLR = 5'h0A,
		FN_BANK0 = 5'h0B,
		FN_BANK1 = 5'h0C,
		FN_BANK2 = 5'h0D,
		FN_RUN = 5'h0E,
		FN_PID_UPD = 5'h0F,
		FN_FILTER = 5'h10,
		FN_WATER = 5'h11,
		FN_TUNE_MODE = 5'h12,
		FN_TUNE1 = 5'h13,
		FN_TUNE2 = 5'h14
	} func_t;

endpackage : event_router_pkg

// ### logic/event_input_function_router.sv
// Event input function router: input qualification, function decode and register port
`timescale 1ns/1ps
`include "event_router_regs.svh"
`default_nettype none

module event_input_function_router #(
	parameter int NUM_INPUTS = `NUM_EVENT_INPUTS,
	parameter int QUAL_CYCLES = `QUAL_TIME_MS * `CLK_FREQ_KHZ
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [NUM_INPUTS-1:0] event_in,
	input wire logic program_done,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [`DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`DATA_W-1:0] reg_rdata,
	output logic stop_ind,
	output logic manual_ind,
	output logic remote_sp_ind,
	output logic tune_ind,
	output logic program_run,
	output logic program_reset,
	output logic program_end,
	output logic reverse_action,
	output logic full_autotune_exec,
	output logic reduced_autotune_exec,
	output logic setting_lock,
	output logic comm_write_permit,
	output logic alarm_latch_clear,
	output logic adaptive_pid_update,
	output logic filter_auto_adjust,
	output logic water_cool_adjust,
	output logic tuning_mode_select,
	output logic tuning_set_one_exec,
	output logic tuning_set_two_exec,
	output logic alarm_eval_enable
);

	localparam int CNT_W = $clog2(QUAL_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(QUAL_CYCLES - 1);

	// Word index of the address reaches eight inputs at most
	generate
		if (NUM_INPUTS < 1 || NUM_INPUTS > 8)
		begin : g_bad_inputs
			$error("NUM_INPUTS must be 1 to 8");
		end
		if (QUAL_CYCLES < 1)
		begin : g_bad_qual
			$error("QUAL_CYCLES must be at least 1");
		end
	endgenerate

	// Input synchronisers and qualification
	logic [NUM_INPUTS-1:0] level_q;
	logic [NUM_INPUTS-1:0] edge_q;

	genvar g;
	generate
		for (g = 0; g < NUM_INPUTS; g++)
		begin : g_in
			logic sync1_r, sync2_r, q_r, valid_r, edge_r;
			logic q_nxt, valid_nxt, edge_nxt;
			logic [CNT_W-1:0] cnt_r, cnt_nxt;

			always_comb
			begin
				q_nxt = q_r;
				valid_nxt = valid_r;
				edge_nxt = 1'b0;
				cnt_nxt = cnt_r;
				// Before the first qualification any level counts, so power-up yields an edge
				if (valid_r && sync2_r == q_r)
					cnt_nxt = '0;
				else if (cnt_r == CNT_LAST)
				begin
					q_nxt = sync2_r;
					valid_nxt = 1'b1;
					edge_nxt = 1'b1;
					cnt_nxt = '0;
				end
				else
					cnt_nxt = cnt_r + 1'b1;
			end

			always_ff @(posedge ref_clk)
			begin
				if (!resetn)
				begin
					sync1_r <= 1'b0;
					sync2_r <= 1'b0;
					q_r <= 1'b0;
					valid_r <= 1'b0;
					edge_r <= 1'b0;
					cnt_r <= '0;
				end
				else
				begin
					sync1_r <= event_in[g];
					sync2_r <= sync1_r;
					q_r <= q_nxt;
					valid_r <= valid_nxt;
					edge_r <= edge_nxt;
					cnt_r <= cnt_nxt;
				end
			end

			assign level_q[g] = q_r;
			assign edge_q[g] = edge_r;
		end
	endgenerate

	// Function assignment per input
	logic [`FUNC_W-1:0] assign_r [NUM_INPUTS];
	logic [`FUNC_W-1:0] assign_nxt [NUM_INPUTS];
	logic [`CFG_W-1:0] cfg_r, cfg_nxt;

	function automatic logic [NUM_INPUTS-1:0] func_mask(input event_router_pkg::func_t f);
		logic [NUM_INPUTS-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_INPUTS; i++)
			m[i] = (assign_r[i] == f);
		return m;
	endfunction : func_mask

	function automatic logic level_of(input event_router_pkg::func_t f);
		return |(func_mask(f) & level_q);
	endfunction : level_of

	function automatic logic on_edge(input event_router_pkg::func_t f);
		return |(func_mask(f) & level_q & edge_q);
	endfunction : on_edge

	function automatic logic off_edge(input event_router_pkg::func_t f);
		return |(func_mask(f) & ~level_q & edge_q);
	endfunction : off_edge

	function automatic logic assigned(input event_router_pkg::func_t f);
		return |func_mask(f);
	endfunction : assigned

	// Execute/cancel latch: set by ON edge, cleared by OFF edge, by losing the assignment or by allow going low
	function automatic logic exec_state(input logic cur, input event_router_pkg::func_t f, input logic allow);
		logic s;
		s = cur;
		if (on_edge(f))
			s = 1'b1;
		if (off_edge(f))
			s = 1'b0;
		return s & allow & assigned(f);
	endfunction : exec_state

	// Control state
	logic stop_r, stop_nxt;
	logic manual_r, manual_nxt;
	logic prog_run_r, prog_run_nxt;
	logic prog_reset_r, prog_reset_nxt;
	logic prog_end_r, prog_end_nxt;
	logic rev_r, rev_nxt;
	logic rsp_r, rsp_nxt;
	logic at_full_r, at_full_nxt;
	logic at_red_r, at_red_nxt;
	logic lock_r, lock_nxt;
	logic comm_r, comm_nxt;
	logic latch_clr_r, latch_clr_nxt;
	logic pid_upd_r, pid_upd_nxt;
	logic filter_r, filter_nxt;
	logic water_r, water_nxt;
	logic tmode_r, tmode_nxt;
	logic tune1_r, tune1_nxt;
	logic tune2_r, tune2_nxt;
	logic alarm_en_r;
	logic heat_cool;

	always_comb
	begin
		// Heating/cooling control disables reduced autotune, PID update, filter adjust, tuning mode and both tuning sets, but not full autotune
		heat_cool = cfg_r[`CFG_HEAT_COOL_BIT];
		stop_nxt = stop_r;
		if (on_edge(event_router_pkg::FN_STOP))
			stop_nxt = 1'b1;
		if (off_edge(event_router_pkg::FN_STOP))
			stop_nxt = 1'b0;
		if (on_edge(event_router_pkg::FN_RUN))
			stop_nxt = 1'b0;
		if (off_edge(event_router_pkg::FN_RUN))
			stop_nxt = 1'b1;
		manual_nxt = level_of(event_router_pkg::FN_MANUAL);
		prog_run_nxt = level_of(event_router_pkg::FN_PROG) & cfg_r[`CFG_PROG_EN_BIT];
		prog_reset_nxt = prog_run_r & ~prog_run_nxt;
		prog_end_nxt = prog_end_r;
		if (prog_reset_nxt)
		begin
			stop_nxt = 1'b1;
			prog_end_nxt = 1'b0;
		end
		// A completion in the reset cycle is kept
		if (program_done && prog_run_r)
			prog_end_nxt = 1'b1;
		rev_nxt = cfg_r[`CFG_REVERSE_BIT] ^ level_of(event_router_pkg::FN_DIR_INV);
		rsp_nxt = level_of(event_router_pkg::FN_SP_SRC) & cfg_r[`CFG_RSP_AVAIL_BIT];
		at_full_nxt = exec_state(at_full_r, event_router_pkg::FN_AT_FULL, 1'b1);
		at_red_nxt = exec_state(at_red_r, event_router_pkg::FN_AT_RED, ~heat_cool);
		lock_nxt = level_of(event_router_pkg::FN_SET_LOCK);
		comm_nxt = level_of(event_router_pkg::FN_COMM_WR);
		latch_clr_nxt = on_edge(event_router_pkg::FN_LATCH_CLR);
		pid_upd_nxt = on_edge(event_router_pkg::FN_PID_UPD) & ~heat_cool;
		filter_nxt = exec_state(filter_r, event_router_pkg::FN_FILTER, ~heat_cool);
		water_nxt = exec_state(water_r, event_router_pkg::FN_WATER, 1'b1);
		tmode_nxt = level_of(event_router_pkg::FN_TUNE_MODE) & ~heat_cool;
		tune1_nxt = exec_state(tune1_r, event_router_pkg::FN_TUNE1, ~heat_cool);
		tune2_nxt = exec_state(tune2_r, event_router_pkg::FN_TUNE2, ~heat_cool);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			stop_r <= 1'b0;
			manual_r <= 1'b0;
			prog_run_r <= 1'b0;
			prog_reset_r <= 1'b0;
			prog_end_r <= 1'b0;
			rev_r <= 1'b0;
			rsp_r <= 1'b0;
			at_full_r <= 1'b0;
			at_red_r <= 1'b0;
			lock_r <= 1'b0;
			comm_r <= 1'b0;
			latch_clr_r <= 1'b0;
			pid_upd_r <= 1'b0;
			filter_r <= 1'b0;
			water_r <= 1'b0;
			tmode_r <= 1'b0;
			tune1_r <= 1'b0;
			tune2_r <= 1'b0;
			alarm_en_r <= 1'b0;
		end
		else
		begin
			stop_r <= stop_nxt;
			manual_r <= manual_nxt;
			prog_run_r <= prog_run_nxt;
			prog_reset_r <= prog_reset_nxt;
			prog_end_r <= prog_end_nxt;
			rev_r <= rev_nxt;
			rsp_r <= rsp_nxt;
			at_full_r <= at_full_nxt;
			at_red_r <= at_red_nxt;
			lock_r <= lock_nxt;
			comm_r <= comm_nxt;
			latch_clr_r <= latch_clr_nxt;
			pid_upd_r <= pid_upd_nxt;
			filter_r <= filter_nxt;
			water_r <= water_nxt;
			tmode_r <= tmode_nxt;
			tune1_r <= tune1_nxt;
			tune2_r <= tune2_nxt;
			// Alarms never look at the run/stop state
			alarm_en_r <= 1'b1;
		end
	end

	// Register port
	logic [`DATA_W-1:0] rdata_r, rdata_nxt;
	logic [`ST_W-1:0] status;
	logic assign_hit;
	logic [`WORD_MSB-`WORD_LSB:0] word_idx;

	always_comb
	begin
		word_idx = reg_addr[`WORD_MSB:`WORD_LSB];
		assign_hit = reg_addr <= `REG_ASSIGN_LAST && reg_addr[`WORD_LSB-1:0] == '0 && int'(word_idx) < NUM_INPUTS;
		status = '0;
		status[`ST_STOP_BIT] = stop_r;
		status[`ST_MANUAL_BIT] = manual_r;
		status[`ST_PROG_RUN_BIT] = prog_run_r;
		status[`ST_PROG_END_BIT] = prog_end_r;
		status[`ST_REV_EFF_BIT] = rev_r;
		status[`ST_RSP_BIT] = rsp_r;
		status[`ST_AT_FULL_BIT] = at_full_r;
		status[`ST_AT_RED_BIT] = at_red_r;
		status[`ST_LOCK_BIT] = lock_r;
		status[`ST_COMM_BIT] = comm_r;
		status[`ST_FILTER_BIT] = filter_r;
		status[`ST_WATER_BIT] = water_r;
		status[`ST_TMODE_BIT] = tmode_r;
		status[`ST_TUNE1_BIT] = tune1_r;
		status[`ST_TUNE2_BIT] = tune2_r;
		status[`ST_ALARM_EN_BIT] = alarm_en_r;
		for (int i = 0; i < NUM_INPUTS; i++)
			assign_nxt[i] = assign_r[i];
		cfg_nxt = cfg_r;
		if (reg_wr && assign_hit)
			assign_nxt[word_idx] = reg_wdata[`FUNC_W-1:0];
		if (reg_wr && reg_addr == `REG_CFG)
			cfg_nxt = reg_wdata[`CFG_W-1:0];
		// Read data stand one cycle only, zero otherwise
		rdata_nxt = '0;
		if (reg_rd)
		begin
			if (assign_hit)
				rdata_nxt = `DATA_W'(assign_r[word_idx]);
			else if (reg_addr == `REG_CFG)
				rdata_nxt = `DATA_W'(cfg_r);
			else if (reg_addr == `REG_STATUS)
				rdata_nxt = `DATA_W'(status);
			else if (reg_addr == `REG_INPUTS)
				rdata_nxt = `DATA_W'(level_q);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < NUM_INPUTS; i++)
				assign_r[i] <= event_router_pkg::FN_NONE;
			cfg_r <= `CFG_RESET;
			rdata_r <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_INPUTS; i++)
				assign_r[i] <= assign_nxt[i];
			cfg_r <= cfg_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign stop_ind = stop_r;
	assign manual_ind = manual_r;
	assign remote_sp_ind = rsp_r;
	assign tune_ind = tmode_r;
	assign program_run = prog_run_r;
	assign program_reset = prog_reset_r;
	assign program_end = prog_end_r;
	assign reverse_action = rev_r;
	assign full_autotune_exec = at_full_r;
	assign reduced_autotune_exec = at_red_r;
	assign setting_lock = lock_r;
	assign comm_write_permit = comm_r;
	assign alarm_latch_clear = latch_clr_r;
	assign adaptive_pid_update = pid_upd_r;
	assign filter_auto_adjust = filter_r;
	assign water_cool_adjust = water_r;
	assign tuning_mode_select = tmode_r;
	assign tuning_set_one_exec = tune1_r;
	assign tuning_set_two_exec = tune2_r;
	assign alarm_eval_enable = alarm_en_r;

endmodule : event_input_function_router

`default_nettype wire

// ### dv/contact_bank.sv
// Contact bank model driving the event inputs
`timescale 1ns/1ps
`default_nettype none
module contact_bank (
	input wire logic ref_clk,
	input wire logic [5:0] want,
	input wire logic chatter,
	output logic [5:0] contacts = 6'h00
);
	// Chatter flips every cycle, so no state is ever held long enough
	always @(posedge ref_clk)
		contacts <= chatter ? ~contacts : want;
endmodule : contact_bank
`default_nettype wire

// ### dv/event_router_sva.sv
// Port assertions for the event input router
`timescale 1ns/1ps
`include "event_router_regs.svh"
`default_nettype none
module event_router_sva #(
	parameter int NUM_INPUTS = 6,
	parameter int QUAL_CYCLES = 8
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic program_done,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [`DATA_W-1:0] reg_rdata,
	input wire logic stop_ind,
	input wire logic tune_ind,
	input wire logic tuning_mode_select,
	input wire logic program_run,
	input wire logic program_reset,
	input wire logic program_end,
	input wire logic alarm_latch_clear,
	input wire logic adaptive_pid_update,
	input wire logic alarm_eval_enable
);
	int quiet_cnt;
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			quiet_cnt <= 0;
		else if (quiet_cnt < QUAL_CYCLES)
			quiet_cnt <= quiet_cnt + 1;
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	sequence rd_mapped;
		reg_rd && reg_addr <= `REG_INPUTS;
	endsequence
	sequence rd_unmapped;
		reg_rd && reg_addr > `REG_INPUTS;
	endsequence
	chk_alarm_always: assert property (resetn |=> alarm_eval_enable)
		else $error("alarm evaluation off");
	chk_quiet_start: assert property (quiet_cnt < QUAL_CYCLES |-> !stop_ind && !program_run)
		else $error("output moved before qualification");
	chk_rd_upper: assert property (rd_mapped |=> reg_rdata[31:16] == 16'h0000)
		else $error("read upper bits set");
	chk_rd_refused: assert property (rd_unmapped |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	chk_latch_pulse: assert property (alarm_latch_clear |=> !alarm_latch_clear)
		else $error("latch clear longer than a cycle");
	chk_pid_pulse: assert property (adaptive_pid_update |=> !adaptive_pid_update)
		else $error("pid update longer than a cycle");
	chk_tune_ind: assert property (tune_ind == tuning_mode_select)
		else $error("tune indicator off mode");
	// A completion in the reset cycle may keep the end flag set
	chk_prog_stop: assert property (program_reset |-> stop_ind && !program_run && (!program_end || $past(program_done)) ##1 !program_reset)
		else $error("program reset did not stop");
	chk_end_cause: assert property ($rose(program_end) |-> $past(program_run))
		else $error("program end without run");
endmodule : event_router_sva
bind event_input_function_router event_router_sva #(.NUM_INPUTS(NUM_INPUTS), .QUAL_CYCLES(QUAL_CYCLES)) i_sva (
	.ref_clk, .resetn, .program_done, .reg_addr, .reg_rd, .reg_rdata, .stop_ind, .tune_ind,
	.tuning_mode_select, .program_run, .program_reset, .program_end, .alarm_latch_clear,
	.adaptive_pid_update, .alarm_eval_enable);
`default_nettype wire

// ### dv/event_input_function_router_tb_top.sv
// Self-checking bench for the event input router
`timescale 1ns/1ps
`include "event_router_regs.svh"
`default_nettype none
module event_input_function_router_tb_top;
	localparam int QUAL = 8;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] want = 6'h00;
	logic chatter = 1'b0;
	wire [5:0] contacts;
	logic program_done = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic stop_ind, manual_ind, remote_sp_ind, tune_ind, program_run, program_reset, program_end;
	logic reverse_action, full_autotune_exec, reduced_autotune_exec, setting_lock, comm_write_permit;
	logic alarm_latch_clear, adaptive_pid_update, filter_auto_adjust, water_cool_adjust;
	logic tuning_mode_select, tuning_set_one_exec, tuning_set_two_exec, alarm_eval_enable;
	int failures = 0;
	int checks_done = 0;
	int pulses = 0;
	int highs = 0;
	contact_bank i_contacts (.ref_clk(ref_clk), .want(want), .chatter(chatter), .contacts(contacts));
	event_input_function_router #(.QUAL_CYCLES(QUAL)) i_dut (.*, .event_in(contacts));
	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		if (alarm_latch_clear || adaptive_pid_update || program_reset)
			pulses <= pulses + 1;
		if (manual_ind)
			highs <= highs + 1;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	// Waits past sync, qualification and output stages
	task automatic push(input logic [5:0] v);
		want <= v;
		repeat (QUAL + 12) @(posedge ref_clk);
	endtask : push
	function automatic logic obs(input int c);
		case (c)
			1, 14: return stop_ind;
			2: return manual_ind;
			3: return program_run;
			4: return reverse_action;
			5: return remote_sp_ind;
			6: return full_autotune_exec;
			7: return reduced_autotune_exec;
			8: return setting_lock;
			9: return comm_write_permit;
			16: return filter_auto_adjust;
			17: return water_cool_adjust;
			18: return tuning_mode_select;
			19: return tuning_set_one_exec;
			20: return tuning_set_two_exec;
			default: return 1'b0;
		endcase
	endfunction : obs
	// Direction invert assumes the reset configuration, reverse action set
	function automatic logic expect_on(input int c, input logic on);
		if (c >= 10 && c <= 13 || c == 15)
			return 1'b0;
		return (c == 14 || c == 4) ? !on : on;
	endfunction : expect_on
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		print_verdict();
	end
	initial
	begin
		logic [31:0] d;
		int idx;
		int p0;
		void'($urandom(32'hCB74B9A0));
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		wr(8'h00, 32'd14);
		repeat (QUAL + 12) @(posedge ref_clk);
		chk("powerup_stop", 1, stop_ind);
		chk("alarm_eval", 1, alarm_eval_enable);
		wr(8'h00, 32'd0);
		rd(`REG_CFG, d);
		chk("cfg", 32'h7, d);
		wr(8'h24, 32'hFFFF_FFFF);
		rd(8'h24, d);
		chk("unmapped", 0, d);
		push(6'h3F);
		chk("unassigned", 7'h48, {stop_ind, manual_ind, program_run, reverse_action, remote_sp_ind,
			setting_lock, comm_write_permit});
		rd(`REG_INPUTS, d);
		chk("inputs", 32'h3F, d);
		push(6'h00);
		for (int c = 1; c <= 20; c++)
		begin
			idx = $urandom % 6;
			wr(8'(idx * 4), c);
			rd(8'(idx * 4), d);
			chk("assign", c, d);
			p0 = pulses;
			push(6'h01 << idx);
			if (c == 3)
			begin
				program_done <= 1'b1;
				@(posedge ref_clk);
				program_done <= 1'b0;
				repeat (3) @(posedge ref_clk);
				chk("prog_end", 1, program_end);
			end
			chk("on", expect_on(c, 1), obs(c));
			chk("pulse_on", (c == 10 || c == 15), pulses - p0);
			push(6'h00);
			chk("off", expect_on(c, 0), obs(c));
			chk("pulse_off", (c == 3 || c == 10 || c == 15), pulses - p0);
			if (c == 3)
				chk("prog_off", 2'b10, {stop_ind, program_end});
			wr(8'(idx * 4), 0);
		end
		// Direct action, no program, no remote set point, heating/cooling
		wr(`REG_CFG, 32'h8);
		for (int c = 3; c <= 7; c += 2)
		begin
			wr(8'h00, c);
			push(6'h01);
			chk("cfg_off", 0, obs(c));
			push(6'h00);
			wr(8'h00, 32'd0);
		end
		chk("direct", 0, reverse_action);
		wr(`REG_CFG, 32'h7);
		wr(8'h00, 32'd2);
		p0 = highs;
		chatter <= 1'b1;
		repeat (QUAL - 2) @(posedge ref_clk);
		chatter <= 1'b0;
		// One cycle short of qualifying
		want <= 6'h01;
		repeat (QUAL - 1) @(posedge ref_clk);
		push(6'h00);
		chk("chatter", 0, highs - p0);
		chk("chatter_level", 0, manual_ind);
		print_verdict();
	end
endmodule : event_input_function_router_tb_top
`default_nettype wire
